// File: logic/boost_supervisor_defines.vh
// Constants for the dual boost converter supervisor
`ifndef BOOST_SUPERVISOR_DEFINES_VH
`define BOOST_SUPERVISOR_DEFINES_VH
// ************************************************************
// Register indices; byte address is four times the index
// ************************************************************
`define IDX_CONTROL 8'h6A
`define IDX_CONV_CFG 8'h76
`define IDX_CONV_FREQ 8'h77
`define ADDR_W 10
// ************************************************************
// Control register fields
// ************************************************************
`define CTL_CONV1_EN 0
`define CTL_CONV2_EN 1
`define CTL_CODEC_EN 10
`define CTL_DSP_EN 11
// ************************************************************
// Converter config register fields
// ************************************************************
`define CFG_RECT1_DIS 0
`define CFG_MODE1_PFM 1
`define CFG_POK1 2
`define CFG_VSEL1_LSB 4
`define CFG_RECT2_DIS 8
`define CFG_MODE2_PFM 9
`define CFG_POK2 10
`define CFG_VSEL2_LSB 12
`define VSEL_W 4
// Code n selects 2.0 V plus n times 0.1 V; code 10 is 3.0 V
`define VSEL_DEFAULT 4'hA
`define VSEL_MAX 4'hF
// ************************************************************
// Converter frequency register fields
// ************************************************************
`define FRQ_SEL_LSB 0
`define FRQ_SEL_W 4
`define FRQ_SEL_DEFAULT 4'h0
`define FRQ_SEL_MAX 4'hE
`define BAT_TWO_CELLS 8
`define BAT_THR_LSB 9
`define BAT_THR_W 4
`define BAT_RESULT 15
// ************************************************************
// Switching frequency: 300 kHz plus 20 kHz per code step
// ************************************************************
`define PCLK_KHZ 14'd10000
`define FRQ_BASE_KHZ 14'd300
`define FRQ_STEP_KHZ 14'd20
`define ACC_W 14
`endif

// File: logic/dual_boost_converter_supervisor.v
// Dual boost converter supervisor with APB register access
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "boost_supervisor_defines.vh"
// Contract
// - Each converter has its own output voltage code, 2.0 V to 3.5 V.
// - Voltage codes default to 3.0 V after start-up.
// - PWM or PFM chosen per converter; PWM by default.
// - Start pin high enables both converters; software enables or disables.
// - PWM switching tick from crystal clock, 300 to 580 kHz selectable.
// - With codec enabled, switching tick locks to codec clock.
// - Crystal clock stops when no PWM and no other block needs it.
// - Rectifier closes when node exceeds output, opens on low current.
// - Disabled converter keeps its rectifier switch closed.
// - Config bits 8 and 0 disable the two synchronous rectifiers.
// - Start with both off restarts both in PWM at 3.0 V.
// - Power good rises with both nominal, falls when both dropped.
// - Battery supervisor watches one or two cells, independent of converters.
// - Host steps thresholds; compare result readable in register 77.
// - Per-converter power-ok flags; power good sets when both are set, clears when both are clear.
module dual_boost_converter_supervisor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  input wire converter_start_pin,
  input wire [1:0] sense_at_nominal,
  input wire [1:0] sense_dropped,
  input wire [1:0] switch_node_above_out,
  input wire [1:0] inductor_current_low,
  input wire battery_compare,
  input wire codec_clk_tick,
  input wire xtal_clk_request,
  output reg [1:0] converter_enable_q,
  output reg [1:0] converter_pfm_q,
  output reg [`VSEL_W-1:0] converter1_vsel_q,
  output reg [`VSEL_W-1:0] converter2_vsel_q,
  output reg [1:0] rectifier_closed_q,
  output reg pwm_switch_tick_q,
  output reg xtal_clk_enable_q,
  output reg power_good_output_q,
  output reg battery_two_cells_q,
  output reg [`BAT_THR_W-1:0] battery_threshold_q
);
  // ************************************************************
  // Synchronised inputs
  // ************************************************************
  wire [9:0] raw_in;
  wire [9:0] syn_in;
  wire start_s;
  wire [1:0] nominal_s;
  wire [1:0] dropped_s;
  wire [1:0] node_above_s;
  wire [1:0] current_low_s;
  wire bat_cmp_s;

  assign raw_in = {battery_compare, converter_start_pin, inductor_current_low,
                   switch_node_above_out, sense_dropped, sense_at_nominal};

  // All analog comparator levels cross into pclk before use
  level_sync #(
    .WIDTH(10)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .sync_out(syn_in)
  );

  assign nominal_s = syn_in[1:0];
  assign dropped_s = syn_in[3:2];
  assign node_above_s = syn_in[5:4];
  assign current_low_s = syn_in[7:6];
  assign start_s = syn_in[8];
  assign bat_cmp_s = syn_in[9];

  // ************************************************************
  // Register state
  // ************************************************************
  reg codec_en_q;
  reg dsp_en_q;
  reg [1:0] rect_dis_q;
  reg [1:0] power_ok_q;
  reg [`FRQ_SEL_W-1:0] freq_sel_q;
  reg bat_result_q;
  wire [1:0] pwm_active;
  wire tick;
  wire wr_access;
  wire [`ADDR_W-3:0] word_idx;
  wire hit_ctl;
  wire hit_cfg;
  wire hit_frq;
  reg [31:0] rd_word;

  // Write takes effect on the access edge that sees pready high
  assign wr_access = psel && penable && pready_q && pwrite;
  assign word_idx = paddr[`ADDR_W-1:2];
  assign hit_ctl = (word_idx == `IDX_CONTROL) && (paddr[1:0] == 2'b00);
  assign hit_cfg = (word_idx == `IDX_CONV_CFG) && (paddr[1:0] == 2'b00);
  assign hit_frq = (word_idx == `IDX_CONV_FREQ) && (paddr[1:0] == 2'b00);

  // ************************************************************
  // Read mux: register images with live status bits
  // ************************************************************
  always @* begin
    rd_word = 32'h0000_0000;
    if (hit_ctl) begin
      rd_word[`CTL_CONV1_EN] = converter_enable_q[0];
      rd_word[`CTL_CONV2_EN] = converter_enable_q[1];
      rd_word[`CTL_CODEC_EN] = codec_en_q;
      rd_word[`CTL_DSP_EN] = dsp_en_q;
    end else if (hit_cfg) begin
      rd_word[`CFG_RECT1_DIS] = rect_dis_q[0];
      rd_word[`CFG_MODE1_PFM] = converter_pfm_q[0];
      rd_word[`CFG_POK1] = power_ok_q[0];
      rd_word[`CFG_VSEL1_LSB +: `VSEL_W] = converter1_vsel_q;
      rd_word[`CFG_RECT2_DIS] = rect_dis_q[1];
      rd_word[`CFG_MODE2_PFM] = converter_pfm_q[1];
      rd_word[`CFG_POK2] = power_ok_q[1];
      rd_word[`CFG_VSEL2_LSB +: `VSEL_W] = converter2_vsel_q;
    end else if (hit_frq) begin
      rd_word[`FRQ_SEL_LSB +: `FRQ_SEL_W] = freq_sel_q;
      rd_word[`BAT_TWO_CELLS] = battery_two_cells_q;
      rd_word[`BAT_THR_LSB +: `BAT_THR_W] = battery_threshold_q;
      rd_word[`BAT_RESULT] = bat_result_q;
    end
  end

  // ************************************************************
  // APB slave: one wait-free access phase, read data sampled in setup
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && !penable;
      if (psel && !penable) begin
        // Unmapped words answer with an error and read as zero
        pslverr_q <= !(hit_ctl || hit_cfg || hit_frq);
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Enables, modes and voltage codes
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable_q <= 2'b00;
      codec_en_q <= 1'b0;
      dsp_en_q <= 1'b0;
      converter_pfm_q <= 2'b00;
      rect_dis_q <= 2'b00;
      converter1_vsel_q <= `VSEL_DEFAULT;
      converter2_vsel_q <= `VSEL_DEFAULT;
    end else begin
      if (wr_access && hit_ctl) begin
        converter_enable_q[0] <= pwdata[`CTL_CONV1_EN];
        converter_enable_q[1] <= pwdata[`CTL_CONV2_EN];
        codec_en_q <= pwdata[`CTL_CODEC_EN];
        dsp_en_q <= pwdata[`CTL_DSP_EN];
      end
      if (wr_access && hit_cfg) begin
        rect_dis_q[0] <= pwdata[`CFG_RECT1_DIS];
        rect_dis_q[1] <= pwdata[`CFG_RECT2_DIS];
        converter_pfm_q[0] <= pwdata[`CFG_MODE1_PFM];
        converter_pfm_q[1] <= pwdata[`CFG_MODE2_PFM];
        converter1_vsel_q <= pwdata[`CFG_VSEL1_LSB +: `VSEL_W];
        converter2_vsel_q <= pwdata[`CFG_VSEL2_LSB +: `VSEL_W];
      end
      // Start pin overrides a same-cycle software disable
      if (start_s) begin
        converter_enable_q <= 2'b11;
        if (converter_enable_q == 2'b00) begin
          // Cold start always comes up in PWM at 3.0 V
          converter_pfm_q <= 2'b00;
          converter1_vsel_q <= `VSEL_DEFAULT;
          converter2_vsel_q <= `VSEL_DEFAULT;
        end
      end
    end
  end

  // ************************************************************
  // Frequency and battery supervisor settings
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_sel_q <= `FRQ_SEL_DEFAULT;
      battery_two_cells_q <= 1'b0;
      battery_threshold_q <= {`BAT_THR_W{1'b0}};
      bat_result_q <= 1'b0;
    end else begin
      if (wr_access && hit_frq) begin
        freq_sel_q <= pwdata[`FRQ_SEL_LSB +: `FRQ_SEL_W];
        battery_two_cells_q <= pwdata[`BAT_TWO_CELLS];
        battery_threshold_q <= pwdata[`BAT_THR_LSB +: `BAT_THR_W];
      end
      // Supervisor runs whatever the converters do
      bat_result_q <= bat_cmp_s;
    end
  end

  // ************************************************************
  // Power-ok flags and combined power good
  // ************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_ok_q <= 2'b00;
      power_good_output_q <= 1'b0;
    end else begin
      // Reaching nominal wins over a simultaneous drop indication
      power_ok_q <= nominal_s | (power_ok_q & ~dropped_s);
      if (power_ok_q == 2'b11) begin
        power_good_output_q <= 1'b1;
      end else if (power_ok_q == 2'b00) begin
        // Hysteresis: one flag dipping must not reset the host
        power_good_output_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Synchronous rectifier switches
  // ************************************************************
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_rect
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rectifier_closed_q[c] <= 1'b1;
        end else if (!converter_enable_q[c]) begin
          // Pass battery straight through to the sense node
          rectifier_closed_q[c] <= 1'b1;
        end else if (rect_dis_q[c]) begin
          rectifier_closed_q[c] <= 1'b0;
        end else if (current_low_s[c]) begin
          rectifier_closed_q[c] <= 1'b0;
        end else if (node_above_s[c]) begin
          rectifier_closed_q[c] <= 1'b1;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Crystal gating and PWM switching tick
  // ************************************************************
  assign pwm_active = converter_enable_q & ~converter_pfm_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xtal_clk_enable_q <= 1'b0;
    end else begin
      // PFM needs no crystal; other users keep it alive
      xtal_clk_enable_q <= (|pwm_active) || codec_en_q || dsp_en_q ||
                           xtal_clk_request;
    end
  end

  switch_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(xtal_clk_enable_q),
    .freq_sel(freq_sel_q),
    .codec_lock(codec_en_q),
    .codec_tick(codec_clk_tick),
    .tick_q(tick)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_switch_tick_q <= 1'b0;
    end else begin
      pwm_switch_tick_q <= tick && (|pwm_active);
    end
  end
endmodule // dual_boost_converter_supervisor

// File: logic/level_sync.v
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module level_sync #(
  parameter WIDTH = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  // ************************************************************
  // One synchroniser per bit; first stage feeds only the second
  // ************************************************************
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate
endmodule // level_sync

// File: logic/switch_tick_gen.v
// Switching tick generator: phase accumulator with codec lock
`timescale 1ns/1ps
`include "boost_supervisor_defines.vh"
module switch_tick_gen (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [`FRQ_SEL_W-1:0] freq_sel,
  input wire codec_lock,
  input wire codec_tick,
  output reg tick_q
);
  reg [`ACC_W-1:0] acc_q;
  reg [`ACC_W-1:0] acc_d;
  reg [`ACC_W-1:0] step;
  reg [`FRQ_SEL_W-1:0] sel_lim;
  reg wrap;
  // ************************************************************
  // Frequency step in kHz; codes above the top clamp to 580 kHz
  // ************************************************************
  always @* begin
    sel_lim = (freq_sel > `FRQ_SEL_MAX) ? `FRQ_SEL_MAX : freq_sel;
    step = `FRQ_BASE_KHZ + `FRQ_STEP_KHZ * {10'h000, sel_lim};
    wrap = ({1'b0, acc_q} + {1'b0, step}) >= {1'b0, `PCLK_KHZ};
    if (wrap) begin
      acc_d = acc_q + step - `PCLK_KHZ;
    end else begin
      acc_d = acc_q + step;
    end
  end
  // Average tick rate equals step kHz with no divider table needed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= {`ACC_W{1'b0}};
      tick_q <= 1'b0;
    end else if (!run) begin
      acc_q <= {`ACC_W{1'b0}};
      tick_q <= 1'b0;
    end else if (codec_lock && codec_tick) begin
      // Realign phase to the codec clock so edges never drift
      acc_q <= {`ACC_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      acc_q <= acc_d;
      tick_q <= wrap;
    end
  end
endmodule // switch_tick_gen

// File: testbench/boost_supervisor_sva.sv
// Assertion checker for the dual boost converter supervisor
`timescale 1ns/1ps
`include "boost_supervisor_defines.vh"
module boost_supervisor_sva (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [`ADDR_W-1:0] paddr,
  input wire pready_q,
  input wire pslverr_q,
  input wire converter_start_pin,
  input wire [1:0] sense_at_nominal,
  input wire xtal_clk_request,
  input wire [1:0] converter_enable_q,
  input wire [1:0] converter_pfm_q,
  input wire [`VSEL_W-1:0] converter1_vsel_q,
  input wire [`VSEL_W-1:0] converter2_vsel_q,
  input wire [1:0] rectifier_closed_q,
  input wire pwm_switch_tick_q,
  input wire xtal_clk_enable_q,
  input wire power_good_output_q
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus slave answers with no wait state
  a_apb_zero_wait: assert property (psel && !penable |=> pready_q)
    else $error("no ready in access cycle");
  a_err_unaligned: assert property
    (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr_q)
    else $error("unaligned access not refused");
  a_start_enables: assert property
    (converter_start_pin [*4] |-> converter_enable_q == 2'h3)
    else $error("start pin did not enable both");
  a_start_defaults: assert property ($past(converter_start_pin, 3) &&
    $past(converter_enable_q) == 2'h0 && converter_enable_q == 2'h3
    |-> converter_pfm_q == 2'h0 && converter1_vsel_q == `VSEL_DEFAULT
    && converter2_vsel_q == `VSEL_DEFAULT)
    else $error("start from off not in default mode");
  // Start pin must cross two flops before it acts
  a_start_synced: assert property ($rose(converter_start_pin) && !psel
    && converter_enable_q == 2'h0 |=> converter_enable_q == 2'h0)
    else $error("start pin used unsynchronised");
  a_pg_rise: assert property
    (sense_at_nominal == 2'h3 [*5] |-> power_good_output_q)
    else $error("power good missing with both nominal");
  a_pg_hold: assert property
    (sense_at_nominal[0] [*5] |-> !$fell(power_good_output_q))
    else $error("power good fell with one flag set");
  a_rect_off_closed: assert property
    (!converter_enable_q[0] [*3] |-> rectifier_closed_q[0])
    else $error("disabled converter rectifier open");
  a_xtal_needed: assert property (((converter_enable_q &
    ~converter_pfm_q) != 2'h0 || xtal_clk_request) [*3] |-> xtal_clk_enable_q)
    else $error("crystal off while needed");
  a_tick_xtal: assert property (pwm_switch_tick_q |-> $past(xtal_clk_enable_q)
    || $past(xtal_clk_enable_q, 2) || $past(xtal_clk_enable_q, 3))
    else $error("switching tick without crystal");
  // Main scenarios reached
  c_pg_up: cover property ($rose(power_good_output_q));
  c_refused: cover property (pslverr_q);
  c_tick: cover property (pwm_switch_tick_q);
endmodule // boost_supervisor_sva
bind dual_boost_converter_supervisor boost_supervisor_sva i_sva (.pclk,
  .presetn, .psel, .penable, .paddr, .pready_q, .pslverr_q,
  .converter_start_pin, .sense_at_nominal, .xtal_clk_request,
  .converter_enable_q, .converter_pfm_q, .converter1_vsel_q,
  .converter2_vsel_q, .rectifier_closed_q, .pwm_switch_tick_q,
  .xtal_clk_enable_q, .power_good_output_q);

// File: testbench/dual_boost_converter_supervisor_tb_top.sv
// Self-checking testbench for the dual boost converter supervisor
`timescale 1ns/1ps
`include "boost_supervisor_defines.vh"
module dual_boost_converter_supervisor_tb_top;
  // ************************************************************
  // Signals and instances
  // ************************************************************
  localparam logic [9:0] A_CTL = {`IDX_CONTROL, 2'h0};
  localparam logic [9:0] A_CFG = {`IDX_CONV_CFG, 2'h0};
  localparam logic [9:0] A_FRQ = {`IDX_CONV_FREQ, 2'h0};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, converter_start_pin = 1'h0, battery_compare = 1'h0;
  logic codec_clk_tick = 1'h0, xtal_clk_request = 1'h0, er;
  logic [`ADDR_W-1:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [1:0] sense_at_nominal = 2'h0, sense_dropped = 2'h0;
  logic [1:0] switch_node_above_out = 2'h0, inductor_current_low = 2'h0;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, pwm_switch_tick_q, xtal_clk_enable_q;
  wire power_good_output_q, battery_two_cells_q;
  wire [1:0] converter_enable_q, converter_pfm_q, rectifier_closed_q;
  wire [3:0] converter1_vsel_q, converter2_vsel_q, battery_threshold_q;
  int bad_count = 0, tests_run = 0, cycles = 0, ticks = 0, host_resets;
  dual_boost_converter_supervisor i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q,
    .converter_start_pin, .sense_at_nominal, .sense_dropped,
    .switch_node_above_out, .inductor_current_low, .battery_compare,
    .codec_clk_tick, .xtal_clk_request, .converter_enable_q,
    .converter_pfm_q, .converter1_vsel_q, .converter2_vsel_q,
    .rectifier_closed_q, .pwm_switch_tick_q, .xtal_clk_enable_q,
    .power_good_output_q, .battery_two_cells_q, .battery_threshold_q);
  host_reset_model i_host (.pclk(pclk),
    .power_good_output_q(power_good_output_q), .reset_count(host_resets));
  // Clock, tick counter and hang guard
  initial forever #50 pclk = ~pclk;
  always @(negedge pclk) ticks += int'(pwm_switch_tick_q === 1'b1);
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Ends on a falling edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  // One bus transfer; waits for ready rather than assuming a latency
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready_q !== 1'b1 && n < 16) begin
      @(negedge pclk);
      n++;
    end
    if (n == 16) chk(32'h0, 32'h1);
    rd = prdata_q;
    er = pslverr_q;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_start;
    chk(32'({converter_enable_q, converter_pfm_q}), 32'h0);
    chk(32'({converter1_vsel_q, converter2_vsel_q}), 32'hAA);
    chk(32'(rectifier_closed_q), 32'h3);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd, 32'h0000A0A0);
    // Reprogram while off; the start pin must restore defaults
    apb(1'b1, A_CFG, 32'h0000A052);
    wt(2);
    chk(32'({converter_pfm_q, converter1_vsel_q}), 32'h15);
    @(posedge pclk);
    converter_start_pin <= 1'b1;
    wt(1);
    chk(32'(converter_enable_q), 32'h0);
    wt(4);
    chk(32'({converter_enable_q, converter_pfm_q, converter1_vsel_q}), 32'hCA);
    @(posedge pclk);
    converter_start_pin <= 1'b0;
    wt(2);
    chk(32'(xtal_clk_enable_q), 32'h1);
  endtask
  task automatic t_pgood;
    @(posedge pclk);
    sense_at_nominal <= 2'h3;
    wt(1);
    chk(32'(power_good_output_q), 32'h0);
    wt(5);
    chk(32'(power_good_output_q), 32'h1);
    apb(1'b0, A_CFG, 32'h0);
    chk(rd & 32'h404, 32'h404);
    @(posedge pclk);
    sense_at_nominal <= 2'h1;
    sense_dropped <= 2'h2;
    wt(6);
    chk(32'(power_good_output_q), 32'h1);
    @(posedge pclk);
    sense_at_nominal <= 2'h0;
    sense_dropped <= 2'h3;
    wt(6);
    chk(32'({power_good_output_q, 4'(host_resets)}), 32'h1);
  endtask
  task automatic t_program;
    apb(1'b1, A_CFG, 32'h0000A0F0);
    wt(2);
    chk(32'({converter1_vsel_q, converter2_vsel_q}), 32'hFA);
    // Host waits for the first power-ok flag before touching the second
    @(posedge pclk);
    sense_at_nominal <= 2'h3;
    do apb(1'b0, A_CFG, 32'h0); while (rd[`CFG_POK1] !== 1'b1);
    apb(1'b1, A_CFG, 32'h000002F0);
    wt(2);
    chk(32'({converter_pfm_q, converter2_vsel_q}), 32'h20);
    // Open on low current first, so the close on a high node is visible
    @(posedge pclk);
    inductor_current_low <= 2'h3;
    wt(3);
    chk(32'(rectifier_closed_q), 32'h0);
    @(posedge pclk);
    inductor_current_low <= 2'h0;
    switch_node_above_out <= 2'h3;
    wt(3);
    chk(32'(rectifier_closed_q), 32'h3);
    // Node still high: only the disable bits can hold the switches open
    apb(1'b1, A_CFG, 32'h000003F1);
    wt(2);
    chk(32'(rectifier_closed_q), 32'h0);
  endtask
  task automatic t_xtal;
    apb(1'b1, A_CFG, 32'h00000202);
    wt(3);
    chk(32'(xtal_clk_enable_q), 32'h0);
    @(posedge pclk);
    xtal_clk_request <= 1'b1;
    wt(3);
    chk(32'(xtal_clk_enable_q), 32'h1);
    @(posedge pclk);
    xtal_clk_request <= 1'b0;
    apb(1'b1, A_CTL, 32'h0);
    wt(3);
    chk(32'({converter_enable_q, rectifier_closed_q, xtal_clk_enable_q}), 32'h6);
  endtask
  task automatic t_freq;
    logic [3:0] codes[4] = '{4'h0, 4'h7, 4'hE, 4'hF};
    int exp;
    apb(1'b1, A_CFG, 32'h0);
    apb(1'b1, A_CTL, 32'h3);
    wt(2);
    chk(32'(converter_enable_q), 32'h3);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, A_FRQ, 32'(codes[i]) | 32'(i << 9) | ((32'(i) & 32'h1) << 8));
      wt(2);
      chk(32'({battery_two_cells_q, battery_threshold_q}), 32'(i[0] * 16 + i));
      @(posedge pclk);
      ticks = 0;
      repeat (1000) @(posedge pclk);
      exp = 100 * (300 + 20 * (codes[i] > 14 ? 14 : codes[i])) / 1000;
      chk(32'(ticks >= exp - 1 && ticks <= exp + 1), 32'h1);
    end
    for (int b = 0; b < 2; b++) begin
      @(posedge pclk);
      battery_compare <= b[0];
      wt(4);
      apb(1'b0, A_FRQ, 32'h0);
      chk(32'(rd[15]), 32'(b));
    end
  endtask
  // Codec ticks every 20 cycles beat the 33-cycle free-running period
  task automatic t_codec;
    apb(1'b1, A_FRQ, 32'h0);
    apb(1'b1, A_CTL, 32'h403);
    @(posedge pclk);
    ticks = 0;
    repeat (20) begin
      repeat (19) @(posedge pclk);
      codec_clk_tick <= 1'b1;
      @(posedge pclk);
      codec_clk_tick <= 1'b0;
    end
    chk(32'(ticks >= 19 && ticks <= 21), 32'h1);
    apb(1'b0, A_CTL, 32'h0);
    chk(rd, 32'h403);
    apb(1'b0, 10'h0, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b0, A_CTL | 10'h2, 32'h0);
    chk(32'(er), 32'h1);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wt(1);
    t_start();
    t_pgood();
    t_program();
    t_xtal();
    t_freq();
    t_codec();
    end_sim();
  end
endmodule // dual_boost_converter_supervisor_tb_top

// File: testbench/host_reset_model.sv
// Model of the host controller reset input fed by power good
`timescale 1ns/1ps
module host_reset_model (
  input wire pclk,
  input wire power_good_output_q,
  output int reset_count
);
  // ************************************************************
  // Reset detection
  // ************************************************************
  logic prev_q = 1'b0;
  initial reset_count = 0;
  // Each fall of power good restarts the host; a dip costs a reset
  always @(negedge pclk) begin
    prev_q <= power_good_output_q;
    if (prev_q === 1'b1 && power_good_output_q === 1'b0) reset_count++;
  end
endmodule // host_reset_model
